// ### hw/pfsa_defines.vh
// Purpose: constants of the program flash self access block
// Assumes: 10 MHz hclk, 32-bit AHB-Lite register bus
// Notes: register byte address is four times its index
`ifndef PFSA_DEFINES_VH
`define PFSA_DEFINES_VH

// ==========================================================
// register indices (byte address = index * 4)
`define PFSA_IDX_CTRL 10'h093
`define PFSA_IDX_UNLOCK 10'h094
`define PFSA_IDX_DATL 10'h095
`define PFSA_IDX_DATH 10'h096
`define PFSA_IDX_ADRL 10'h097
`define PFSA_IDX_ADRH 10'h098

// ==========================================================
// field positions and reset values
`define PFSA_CTRL_RD 0
`define PFSA_CTRL_WR 1
`define PFSA_CTRL_PERMIT 2
`define PFSA_CTRL_FIXED1 7
`define PFSA_ADRH_W 3
`define PFSA_DATH_W 6
`define PFSA_RST_BYTE 8'h00
`define PFSA_RST_WORD 14'h0000
`define PFSA_KEY1 8'h55
`define PFSA_KEY2 8'hAA
`define PFSA_LAST_WORD 2'h3
`define PFSA_FLASH_TOP 13'h07FF

// ==========================================================
// timing
`define PFSA_CLK_MHZ 10
`define PFSA_SETUP_CYC 2
`define PFSA_ERASE_TIME_US 4000
`define PFSA_PROG_TIME_US 2000
`define PFSA_PWRT_TIME_US 64000

// ==========================================================
// write-protect selections
`define PFSA_WP_ALL 2'h0
`define PFSA_WP_HALF 2'h1
`define PFSA_WP_LOW 2'h2
`define PFSA_WP_HALF_TOP 13'h03FF
`define PFSA_WP_LOW_TOP 13'h00FF

`endif

// ### hw/pfsa_ctrl.v
// Purpose: program flash self read and self write controller
// Assumes: one hclk domain, flash array answers a read next cycle
// Notes: zero-wait writes, one-wait reads on the register bus
`timescale 1ns/10ps
`include "pfsa_defines.vh"

// Contract
// - data pair: low register bits 7..0, high register upper six bits
// - flash address built from high byte and low byte registers
// - array holds 2K words 0000h-07FFh; address pair spans the same 2K
// - single word reads, four word group writes
// - last word write erases row then programs, no erase command
// - write duration timed by internal timer
// - code protection still allows core reads and writes
// - write-protect setting blocks writes to regions, reads allowed
// - code protect denies external serial programmer all access
// - high address register keeps bits 2..0, rest read zero
// - software only sets triggers; hardware clears them at completion
// - write permit at control bit 2, zero at power-up, inhibits writes
// - unlock port has no storage, reads zero, serves unlock only
// - fetched word lands in data registers next cycle and holds
// - read completes in two cycles then trigger clears itself
// - control bit 7 reads one, bits 6..3 read zero
// - high data register bits 5..0 valid, bits 7..6 read zero
// - low address bits 11 erase and program; others only buffer
// - two setup cycles after write trigger before erase or write
module pfsa_ctrl #(
  parameter ERASE_CYC = `PFSA_ERASE_TIME_US * `PFSA_CLK_MHZ,
  parameter PROG_CYC = `PFSA_PROG_TIME_US * `PFSA_CLK_MHZ,
  parameter PWRT_CYC = `PFSA_PWRT_TIME_US * `PFSA_CLK_MHZ
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg [10:0] flash_addr,
  output reg flash_rd_en,
  input wire [13:0] flash_rdata,
  output reg flash_erase,
  output reg flash_prog,
  output wire [55:0] flash_wdata,
  input wire [1:0] write_protect_select,
  input wire code_protect_n,
  input wire serial_programming_port_req,
  output wire serial_programming_port_grant,
  output wire core_hold
);

  // ==========================================================
  // states
  localparam ST_IDLE = 3'h0;
  localparam ST_RDA = 3'h1;
  localparam ST_RDB = 3'h2;
  localparam ST_SETUP = 3'h3;
  localparam ST_ERASE = 3'h4;
  localparam ST_PROG = 3'h5;

  // ==========================================================
  // registers
  reg [7:0] flash_address_low_q;
  reg [2:0] flash_address_high_q;
  reg [7:0] flash_data_low_q;
  reg [5:0] flash_data_high_q;
  reg write_permit_q;
  reg rd_trig_q;
  reg wr_trig_q;
  reg [1:0] unlock_q;
  reg [2:0] state_q;
  reg [19:0] timer_q;
  reg [19:0] pwrt_q;
  reg pwrt_done_q;
  reg [13:0] buf_q [0:3];
  reg [1:0] wp_s1_q;
  reg [1:0] wp_q;
  reg cp_s1_q;
  reg cp_n_q;
  reg ser_s1_q;
  reg ser_q;

  // bus pipeline
  reg wr_pend_q;
  reg [9:0] wr_idx_q;
  reg rd_wait_q;
  reg [9:0] rd_idx_q;

  wire [12:0] full_addr;
  wire in_array;
  wire wp_hit;
  wire bus_req;
  wire do_wr;
  wire [7:0] wbyte;
  wire wr_ctrl;
  wire wr_unlock;
  wire wr_start;
  wire rd_start;
  wire read_done;
  wire setup_last;
  wire wr_done_c;
  reg wp_hit_c;

  // ==========================================================
  // configuration inputs, two-stage synchronised
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_s1_q <= 2'h0;
      wp_q <= 2'h0;
      cp_s1_q <= 1'b0;
      cp_n_q <= 1'b0;
      ser_s1_q <= 1'b0;
      ser_q <= 1'b0;
    end else begin
      wp_s1_q <= write_protect_select;
      wp_q <= wp_s1_q;
      cp_s1_q <= code_protect_n;
      cp_n_q <= cp_s1_q;
      ser_s1_q <= serial_programming_port_req;
      ser_q <= ser_s1_q;
    end
  end

  // external programmer blocked while protected
  assign serial_programming_port_grant = ser_q & cp_n_q;

  // ==========================================================
  // power-up write lockout
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwrt_q <= 20'h00000;
      pwrt_done_q <= 1'b0;
    end else if (!pwrt_done_q) begin
      pwrt_q <= pwrt_q + 20'h00001;
      pwrt_done_q <= (pwrt_q == PWRT_CYC[19:0] - 20'h00001);
    end
  end

  // ==========================================================
  // address and protection
  assign full_addr = {2'h0, flash_address_high_q, flash_address_low_q};
  assign in_array = (full_addr <= `PFSA_FLASH_TOP);

  always @* begin
    case (wp_q)
      `PFSA_WP_ALL: wp_hit_c = 1'b1;
      `PFSA_WP_HALF: wp_hit_c = (full_addr <= `PFSA_WP_HALF_TOP);
      `PFSA_WP_LOW: wp_hit_c = (full_addr <= `PFSA_WP_LOW_TOP);
      default: wp_hit_c = 1'b0;
    endcase
  end
  // code protect plays no part in core access
  assign wp_hit = wp_hit_c;

  // ==========================================================
  // AHB-Lite slave: writes zero wait, reads one wait state
  assign bus_req = hsel & hready & htrans[1];
  assign hreadyout = ~rd_wait_q;
  assign hresp = 1'b0;
  assign do_wr = wr_pend_q;
  assign wbyte = hwdata[7:0];
  assign wr_ctrl = do_wr & (wr_idx_q == `PFSA_IDX_CTRL);
  assign wr_unlock = do_wr & (wr_idx_q == `PFSA_IDX_UNLOCK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
      rd_wait_q <= 1'b0;
      rd_idx_q <= 10'h000;
    end else begin
      wr_pend_q <= bus_req & hwrite;
      rd_wait_q <= bus_req & ~hwrite;
      if (bus_req) begin
        wr_idx_q <= haddr[11:2];
        rd_idx_q <= haddr[11:2];
      end
    end
  end

  // read data, sampled in the wait cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_wait_q) begin
      case (rd_idx_q)
        `PFSA_IDX_CTRL: begin
          hrdata <= {24'h000000, 1'b1, 4'h0, write_permit_q,
            wr_trig_q, rd_trig_q};
        end
        `PFSA_IDX_DATL: hrdata <= {24'h000000, flash_data_low_q};
        `PFSA_IDX_DATH: hrdata <= {26'h0000000, flash_data_high_q};
        `PFSA_IDX_ADRL: hrdata <= {24'h000000, flash_address_low_q};
        `PFSA_IDX_ADRH: hrdata <= {29'h00000000, flash_address_high_q};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // unlock sequence tracker
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unlock_q <= 2'h0;
    end else if (do_wr) begin
      if (wr_unlock && wbyte == `PFSA_KEY1) begin
        unlock_q <= 2'h1;
      end else if (wr_unlock && wbyte == `PFSA_KEY2 && unlock_q == 2'h1) begin
        unlock_q <= 2'h2;
      end else begin
        unlock_q <= 2'h0;
      end
    end
  end

  // ==========================================================
  // trigger qualification
  assign rd_start = wr_ctrl & wbyte[`PFSA_CTRL_RD] & (state_q == ST_IDLE);
  assign wr_start = wr_ctrl & wbyte[`PFSA_CTRL_WR] & (state_q == ST_IDLE) &
    ~rd_start & write_permit_q & pwrt_done_q & (unlock_q == 2'h2);
  assign read_done = (state_q == ST_RDB);
  assign setup_last = (state_q == ST_SETUP) &&
    (timer_q == `PFSA_SETUP_CYC - 1);

  // control register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_permit_q <= 1'b0;
      rd_trig_q <= 1'b0;
      wr_trig_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        write_permit_q <= wbyte[`PFSA_CTRL_PERMIT];
      end
      // set only; cleared by the sequencer
      if (rd_start) begin
        rd_trig_q <= 1'b1;
      end else if (read_done) begin
        rd_trig_q <= 1'b0;
      end
      if (wr_start) begin
        wr_trig_q <= 1'b1;
      end else if (wr_done_c) begin
        wr_trig_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // write completion: buffered or refused words finish after setup
  assign wr_done_c = setup_last ?
    ((full_addr[1:0] != `PFSA_LAST_WORD) | wp_hit | ~in_array) :
    ((state_q == ST_PROG) && (timer_q == PROG_CYC[19:0] - 20'h00001));
  assign core_hold = (state_q == ST_ERASE) | (state_q == ST_PROG);

  // ==========================================================
  // sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      timer_q <= 20'h00000;
      flash_rd_en <= 1'b0;
      flash_erase <= 1'b0;
      flash_prog <= 1'b0;
      flash_addr <= 11'h000;
    end else begin
      flash_rd_en <= 1'b0;
      flash_erase <= 1'b0;
      flash_prog <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          timer_q <= 20'h00000;
          flash_addr <= full_addr[10:0];
          if (rd_start) begin
            state_q <= ST_RDA;
            flash_rd_en <= in_array;
          end else if (wr_start) begin
            state_q <= ST_SETUP;
          end
        end
        ST_RDA: state_q <= ST_RDB;
        ST_RDB: state_q <= ST_IDLE;
        ST_SETUP: begin
          timer_q <= timer_q + 20'h00001;
          if (setup_last) begin
            timer_q <= 20'h00000;
            if (wr_done_c) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_ERASE;
              flash_erase <= 1'b1;
            end
          end
        end
        ST_ERASE: begin
          timer_q <= timer_q + 20'h00001;
          if (timer_q == ERASE_CYC[19:0] - 20'h00001) begin
            timer_q <= 20'h00000;
            state_q <= ST_PROG;
            flash_prog <= 1'b1;
          end
        end
        ST_PROG: begin
          timer_q <= timer_q + 20'h00001;
          if (wr_done_c) begin
            timer_q <= 20'h00000;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // data registers: read result wins over a same-cycle bus write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_data_low_q <= `PFSA_RST_BYTE;
      flash_data_high_q <= 6'h00;
      flash_address_low_q <= `PFSA_RST_BYTE;
      flash_address_high_q <= 3'h0;
    end else begin
      if (read_done) begin
        flash_data_low_q <= in_array ? flash_rdata[7:0] : 8'h00;
        flash_data_high_q <= in_array ? flash_rdata[13:8] : 6'h00;
      end else if (do_wr && wr_idx_q == `PFSA_IDX_DATL) begin
        flash_data_low_q <= wbyte;
      end else if (do_wr && wr_idx_q == `PFSA_IDX_DATH) begin
        flash_data_high_q <= wbyte[`PFSA_DATH_W-1:0];
      end
      if (do_wr && wr_idx_q == `PFSA_IDX_ADRL && state_q == ST_IDLE) begin
        flash_address_low_q <= wbyte;
      end
      if (do_wr && wr_idx_q == `PFSA_IDX_ADRH && state_q == ST_IDLE) begin
        flash_address_high_q <= wbyte[`PFSA_ADRH_W-1:0];
      end
    end
  end

  // ==========================================================
  // four-word write buffer
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        buf_q[i] <= `PFSA_RST_WORD;
      end
    end else if (setup_last && !wp_hit && in_array) begin
      buf_q[full_addr[1:0]] <= {flash_data_high_q, flash_data_low_q};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_wdata
      assign flash_wdata[g*14 +: 14] = buf_q[g];
    end
  endgenerate

endmodule // pfsa_ctrl

// ### tb/pfsa_ctrl_checker.sv
// Purpose: port checks for pfsa_ctrl
// Assumes: one hclk domain
// Notes: bound to every pfsa_ctrl
`timescale 1ns/10ps
module pfsa_ctrl_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [10:0] flash_addr,
  input wire flash_rd_en,
  input wire flash_erase,
  input wire flash_prog,
  input wire [1:0] write_protect_select,
  input wire code_protect_n,
  input wire serial_programming_port_req,
  input wire serial_programming_port_grant,
  input wire core_hold
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1];
  reg erased_q;
  // ==========================================
  // erase seen and not yet programmed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) erased_q <= 1'h0;
    else if (flash_erase || flash_prog) erased_q <= flash_erase;
  end
  sequence rd_at(idx);
    take && !hwrite && haddr[11:2] == idx;
  endsequence
  sequence wait_one;
    !hreadyout ##1 hreadyout;
  endsequence
  okay_resp_a: assert property (hresp == 1'h0)
    else $error("bad response");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write waited");
  ctrl_fixed_a: assert property (rd_at(10'h093) |=> wait_one ##0 hrdata[7:3] == 5'h10)
    else $error("ctrl fixed bits");
  unlock_zero_a: assert property (rd_at(10'h094) |=> wait_one ##0 hrdata == 32'h0)
    else $error("unlock not zero");
  rd_pulse_a: assert property (flash_rd_en |=> !flash_rd_en)
    else $error("read strobe long");
  prog_after_erase_a: assert property (flash_prog |-> erased_q)
    else $error("program without erase");
  erase_hold_a: assert property (flash_erase |-> ##[0:2] core_hold)
    else $error("no hold on erase");
  last_word_a: assert property (flash_erase |-> flash_addr[1:0] == 2'h3)
    else $error("erase not on last word");
  protect_all_a: assert property ((write_protect_select == 2'h0) [*4] |-> !flash_erase)
    else $error("protected erase");
  serial_grant_a: assert property (
    (serial_programming_port_req && code_protect_n) [*4] |-> serial_programming_port_grant)
    else $error("grant missing");
  serial_deny_a: assert property ((!code_protect_n) [*4] |-> !serial_programming_port_grant)
    else $error("grant while protected");
endmodule // pfsa_ctrl_checker
bind pfsa_ctrl pfsa_ctrl_checker pfsa_ctrl_checker_inst (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .flash_addr, .flash_rd_en,
  .flash_erase, .flash_prog, .write_protect_select, .code_protect_n,
  .serial_programming_port_req, .serial_programming_port_grant, .core_hold);

// ### tb/pfsa_flash_model.sv
// Purpose: behavioural program flash array
// Assumes: word read answered in the cycle after the strobe
// Notes: output churns when not answering
`timescale 1ns/10ps
module pfsa_flash_model (
  input wire hclk,
  input wire [10:0] flash_addr,
  input wire flash_rd_en,
  output reg [13:0] flash_rdata,
  input wire flash_erase,
  input wire flash_prog,
  input wire [55:0] flash_wdata
);
  reg [13:0] mem [0:2047];
  integer i;
  initial begin
    for (i = 0; i < 2048; i = i + 1) mem[i] = i[13:0] ^ 14'h1A5C;
    flash_rdata = 14'h0000;
  end
  always @(posedge hclk) begin
    flash_rdata <= flash_rd_en ? mem[flash_addr] : ~flash_rdata;
    if (flash_erase)
      for (i = 0; i < 16; i = i + 1) mem[{flash_addr[10:4], i[3:0]}] <= 14'h3FFF;
    if (flash_prog)
      for (i = 0; i < 4; i = i + 1)
        mem[{flash_addr[10:2], i[1:0]}] <= flash_wdata[14*i +: 14];
  end
endmodule // pfsa_flash_model

// ### tb/pfsa_ctrl_bench.sv
// Purpose: self-checking bench for pfsa_ctrl
// Assumes: shortened erase, program and power-up counts
// Notes: register reads checked from a queue
`timescale 1ns/10ps
module pfsa_ctrl_bench;
  localparam [9:0] IC = 10'h093;
  localparam [9:0] IU = 10'h094;
  localparam [9:0] IDL = 10'h095;
  localparam [9:0] IDH = 10'h096;
  localparam [9:0] IAL = 10'h097;
  localparam [9:0] IAH = 10'h098;
  reg hclk = 1'h0;
  reg hresetn = 1'h0;
  reg hsel = 1'h0;
  reg hwrite = 1'h0;
  reg [31:0] haddr = 32'h0;
  reg [31:0] hwdata = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [1:0] write_protect_select = 2'h3;
  reg code_protect_n = 1'h1;
  reg serial_programming_port_req = 1'h1;
  reg rpend = 1'h0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire [10:0] flash_addr;
  wire flash_rd_en;
  wire flash_erase;
  wire flash_prog;
  wire [13:0] flash_rdata;
  wire [55:0] flash_wdata;
  wire core_hold;
  logic [31:0] expq[$];
  int errors = 0;
  int num_checks = 0;
  int k;
  logic [10:0] b;
  logic [13:0] wd [0:4];
  pfsa_ctrl #(.ERASE_CYC(20), .PROG_CYC(10), .PWRT_CYC(8)) pfsa_ctrl_inst (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp(), .flash_addr, .flash_rd_en, .flash_rdata, .flash_erase, .flash_prog,
    .flash_wdata, .write_protect_select, .code_protect_n, .serial_programming_port_req,
    .serial_programming_port_grant(), .core_hold);
  pfsa_flash_model pfsa_flash_model_inst (.hclk, .flash_addr, .flash_rd_en, .flash_rdata,
    .flash_erase, .flash_prog, .flash_wdata);
  // ==========================================
  // bus tasks
  task xfer(input [9:0] idx, input w, input [7:0] d);
    begin
      hsel <= 1'h1;
      haddr <= {20'h0, idx, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= ($urandom & 32'hFFFFFF00) | {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'h1);
    end
  endtask
  task wr(input [9:0] idx, input [7:0] d);
    xfer(idx, 1'h1, d);
  endtask
  task rd(input [9:0] idx, input [7:0] e);
    begin
      expq.push_back({24'h0, e});
      xfer(idx, 1'h0, 8'h00);
    end
  endtask
  task fread(input [12:0] a);
    begin
      wr(IAL, a[7:0]);
      wr(IAH, {3'h0, a[12:8]});
      wr(IC, 8'h05);
      @(posedge hclk);
    end
  endtask
  task fwrite(input [10:0] a, input [13:0] d);
    begin
      wr(IAL, a[7:0]);
      wr(IAH, {5'h0, a[10:8]});
      wr(IDL, d[7:0]);
      wr(IDH, {2'h0, d[13:8]});
      wr(IU, 8'h55);
      wr(IU, 8'hAA);
      wr(IC, 8'h06);
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        errors++;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ==========================================
  // read monitor, clock, watchdog
  always @(posedge hclk) begin
    if (rpend && hreadyout) cmp(hrdata, expq.pop_front());
    if (hreadyout) rpend <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    forever #50 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    final_report;
  end
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(32'h9520CEAF));
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (10) @(posedge hclk);
    rd(IC, 8'h80);
    for (k = 0; k < 5; k++) rd(IU + k[9:0], 8'h00);
    wr(IAH, 8'hFF);
    rd(IAH, 8'h07);
    wr(IDH, 8'hFF);
    rd(IDH, 8'h3F);
    wr(IC, 8'h7C);
    rd(IC, 8'h84);
    for (k = 0; k < 5; k++) begin
      b = (k == 4) ? 11'h7FF : 11'($urandom);
      wd[0] = {3'h0, b} ^ 14'h1A5C;
      fread({2'h0, b});
      rd(IDL, wd[0][7:0]);
      rd(IDH, {2'h0, wd[0][13:8]});
      rd(IC, 8'h84);
    end
    fread(13'h0800);
    rd(IDL, 8'h5C);
    rd(IDH, 8'h1A);
    wr(IDL, 8'h3C);
    rd(IDL, 8'h3C);
    wr(IC, 8'h06);
    rd(IC, 8'h84);
    wr(IU, 8'h55);
    wr(IDL, 8'h11);
    wr(IU, 8'hAA);
    wr(IC, 8'h06);
    rd(IC, 8'h84);
    b = {7'($urandom), 4'h0};
    wd[4] = 14'h3FFF;
    for (k = 0; k < 4; k++) begin
      wd[k] = 14'($urandom);
      fwrite(b + k[10:0], wd[k]);
      rd(IC, 8'h86);
      if (k == 3) wr(IC, 8'h04);
      rd(IC, (k == 3) ? 8'h86 : 8'h84);
    end
    repeat (40) @(posedge hclk);
    rd(IC, 8'h84);
    for (k = 0; k < 5; k++) begin
      fread({2'h0, b + k[10:0]});
      rd(IDL, wd[k][7:0]);
      rd(IDH, {2'h0, wd[k][13:8]});
    end
    write_protect_select <= 2'h0;
    code_protect_n <= 1'h0;
    repeat (4) @(posedge hclk);
    fwrite(b + 11'h3, ~wd[3]);
    repeat (4) @(posedge hclk);
    rd(IC, 8'h84);
    fread({2'h0, b + 11'h3});
    rd(IDL, wd[3][7:0]);
    write_protect_select <= 2'h3;
    repeat (4) @(posedge hclk);
    fwrite(b + 11'h3, ~wd[3]);
    repeat (40) @(posedge hclk);
    fread({2'h0, b + 11'h3});
    rd(IDL, ~wd[3][7:0]);
    rd(IDH, {2'h0, ~wd[3][13:8]});
    repeat (4) @(posedge hclk);
    final_report;
  end
endmodule // pfsa_ctrl_bench
